/* File: hw/_unused_placeholder_removed.sv */
// Intentionally empty.
`timescale 1ns/10ps

/* File: hw/sgc_consts.svh */
// Constants of the frame buffer memory controller: encodings and timing.
// Assumes the memory clock runs at the system clock rate.
`ifndef SGC_CONSTS_SVH
`define SGC_CONSTS_SVH

// Data bus widths of the two array configurations
`define SGC_DW_NARROW 64
`define SGC_DW_WIDE 128
`define SGC_ADDR_W 10

// Command pins {cs_n, ras_n, cas_n, we_n}
`define SGC_CMD_INH 4'hF
`define SGC_CMD_NOP 4'h7
`define SGC_CMD_ACT 4'h3
`define SGC_CMD_RD 4'h5
`define SGC_CMD_WR 4'h4
`define SGC_CMD_PRE 4'h2
`define SGC_CMD_LMR 4'h0

// Address fields
`define SGC_ADDR_BANK 9
`define SGC_ADDR_AP 8

// Mode opcode fields and values
`define SGC_MODE_BL_LSB 0
`define SGC_MODE_BT_BIT 3
`define SGC_MODE_CL_LSB 4
`define SGC_MODE_BL_ONE 3'h0
`define SGC_MODE_CL2 3'h2
`define SGC_MODE_CL3 3'h3

// Timing in memory clock periods, then in system clock cycles
`define SGC_CYC_PER_TCK 1
`define SGC_T_RCD_TCK 3
`define SGC_T_RP_TCK 4
`define SGC_T_RAS_TCK 7
`define SGC_T_MRD_TCK 2
`define SGC_T_WR_TCK 2
`define SGC_RCD_CYC (`SGC_T_RCD_TCK * `SGC_CYC_PER_TCK)
`define SGC_RP_CYC (`SGC_T_RP_TCK * `SGC_CYC_PER_TCK)
`define SGC_RAS_CYC (`SGC_T_RAS_TCK * `SGC_CYC_PER_TCK)
`define SGC_MRD_CYC (`SGC_T_MRD_TCK * `SGC_CYC_PER_TCK)
`define SGC_WR_CYC (`SGC_T_WR_TCK * `SGC_CYC_PER_TCK)

`endif

/* File: hw/sgc_ctrl.sv */
// Frame buffer memory controller: init sequence, row tracking, commands.
// Assumes the memory clock equals clk_sys_i and requests share that clock.
//
// Functional notes
// - Data bus is 64 bits for the small array, 128 for the large.
// - Every access first activates its row; reads and writes follow.
// - One beat per access; a new read or write may issue every cycle.
// - All memory pins change and are sampled on the rising clock edge.
// - Clock enable high, special function low; inhibit and nop encodings.
// - Activate is cs, ras low; bank on bit 9, row on bits 8..0.
// - Read is cs, cas low; bank bit 9, bit 8 zero, column 7..0.
// - Write is a read with write strobe low; data in same cycle.
// - Precharge is cs, ras, we low with bit 8 set; closes both banks.
// - Load mode drives all four strobes low, opcode on bits 8..0.
// - Mask low enables data; no delay on writes, two clocks on reads.
// - Column given with a read or write selects the accessed column.
// - First command issues on the third edge after host reset release; two go to the synchroniser.
// - Init precharges all banks, then loads mode, before any access.
// - Burst length field of the opcode is zero, one beat.
// - Read latency field of the opcode is two or three.
// - At least three clocks from activate to read or write.
// - At least four clocks from precharge to the next activate.
// - A row stays active at least seven clocks before precharge.
// - At least two clocks from load mode to the next command.
`timescale 1ns/10ps
`include "sgc_consts.svh"

module sgc_ctrl #(
    parameter int DW = `SGC_DW_NARROW
) (
    input logic clk_sys_i,
    input logic nrst_i,
    input logic host_reset_n_i,
    input logic cfg_read_lat3_i,
    input sgc_pkg::sgc_req_t req_i,
    input logic [DW-1:0] req_wdata_i,
    output logic req_ready_o,
    output logic init_done_o,
    output logic rd_valid_o,
    output logic [DW-1:0] rd_data_o,
    output logic mem_chip_select_n_o,
    output logic row_strobe_n_o,
    output logic column_strobe_n_o,
    output logic write_strobe_n_o,
    output logic mem_clock_enable_o,
    output logic special_function_select_o,
    output logic [`SGC_ADDR_W-1:0] mem_addr_o,
    output logic [DW/8-1:0] byte_mask_o,
    output logic [DW-1:0] mem_data_o,
    output logic mem_data_oe_o,
    input logic [DW-1:0] mem_data_i
);
    localparam int MW = DW / 8;

    // only the two array widths are served
    if (DW != `SGC_DW_NARROW && DW != `SGC_DW_WIDE) begin : g_chk
        $error("sgc_ctrl: DW must be 64 or 128");
    end

    typedef struct packed {
        sgc_pkg::sgc_fsm_t st;
        logic [3:0] wait_cnt;
        logic [3:0] ras_cnt;
        logic [1:0] rd_busy;
        logic open;
        logic obank;
        logic [8:0] orow;
        logic cl3;
        logic pend;
        logic pwr;
        logic pbank;
        logic [8:0] prow;
        logic [7:0] pcol;
        logic [DW-1:0] pdata;
        sgc_pkg::sgc_cmd_t cmd;
        logic [`SGC_ADDR_W-1:0] addr;
        logic [MW-1:0] mask;
        logic [DW-1:0] dout;
        logic oe;
        logic cke;
        logic iss_rd;
        logic ready;
        logic done;
    } sgc_regs_t;

    sgc_regs_t s_q, s_d;
    logic host_up;
    logic take;
    logic cur_v;
    logic cur_wr;
    logic cur_bank;
    logic [8:0] cur_row;
    logic [7:0] cur_col;
    logic [DW-1:0] cur_data;
    logic hit;
    logic rw_ok;

    // Host reset comes from a pin, so it is synchronised first
    sgc_sync #(
        .W(1)
    ) u_host_sync (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .async_i(host_reset_n_i),
        .sync_o(host_up)
    );

    assign take = req_i.valid && s_q.ready;
    assign cur_v = s_q.pend || take;
    assign cur_wr = s_q.pend ? s_q.pwr : req_i.write;
    assign cur_bank = s_q.pend ? s_q.pbank : req_i.bank;
    assign cur_row = s_q.pend ? s_q.prow : req_i.row;
    assign cur_col = s_q.pend ? s_q.pcol : req_i.col;
    assign cur_data = s_q.pend ? s_q.pdata : req_wdata_i;
    assign hit = s_q.open && cur_bank == s_q.obank && cur_row == s_q.orow;
    // Writes wait until the last read beat has left the shared data bus
    assign rw_ok = cur_v && hit && s_q.wait_cnt == 4'h0
        && !(cur_wr && s_q.rd_busy != 2'h0);

    always_comb begin
        s_d = s_q;
        // idle cycles are nops with clock enable held high
        s_d.cmd = sgc_pkg::sgc_cmd_t'(`SGC_CMD_NOP);
        s_d.cke = 1'b1;
        s_d.mask = '1;
        s_d.oe = 1'b0;
        s_d.iss_rd = 1'b0;
        if (s_q.wait_cnt != 4'h0) begin
            s_d.wait_cnt = s_q.wait_cnt - 4'h1;
        end
        if (s_q.ras_cnt != 4'h0) begin
            s_d.ras_cnt = s_q.ras_cnt - 4'h1;
        end
        if (s_q.rd_busy != 2'h0) begin
            s_d.rd_busy = s_q.rd_busy - 2'h1;
        end
        // read mask is two clocks ahead, so latency three lags a cycle
        if (s_q.iss_rd && s_q.cl3) begin
            s_d.mask = '0;
        end
        case (s_q.st)
            sgc_pkg::SGC_ST_RESET: begin
                s_d.cmd = sgc_pkg::sgc_cmd_t'(`SGC_CMD_INH);
                s_d.open = 1'b0;
                s_d.pend = 1'b0;
                s_d.done = 1'b0;
                // precharge goes out on the first edge after the synchronised release
                if (host_up) begin
                    s_d.cmd = sgc_pkg::sgc_cmd_t'(`SGC_CMD_PRE);
                    s_d.addr = '0;
                    s_d.addr[`SGC_ADDR_AP] = 1'b1;
                    s_d.wait_cnt = 4'(`SGC_RP_CYC - 1);
                    s_d.cl3 = cfg_read_lat3_i;
                    s_d.st = sgc_pkg::SGC_ST_INIT_PRE;
                end
            end
            sgc_pkg::SGC_ST_INIT_PRE: begin
                // then program the mode register once idle
                if (s_q.wait_cnt == 4'h0) begin
                    // load mode, opcode on bits 8..0
                    s_d.cmd = sgc_pkg::sgc_cmd_t'(`SGC_CMD_LMR);
                    s_d.addr = '0;
                    s_d.addr[`SGC_MODE_BL_LSB +: 3] = `SGC_MODE_BL_ONE;
                    // burst type left zero, memory ignores it
                    s_d.addr[`SGC_MODE_BT_BIT] = 1'b0;
                    s_d.addr[`SGC_MODE_CL_LSB +: 3] = s_q.cl3 ?
                        `SGC_MODE_CL3 : `SGC_MODE_CL2;
                    // load mode to next command gap
                    s_d.wait_cnt = 4'(`SGC_MRD_CYC - 1);
                    s_d.st = sgc_pkg::SGC_ST_INIT_MRD;
                end
            end
            sgc_pkg::SGC_ST_INIT_MRD: begin
                // mode is loaded once and relied on from here
                if (s_q.wait_cnt == 4'h0) begin
                    s_d.done = 1'b1;
                    s_d.st = sgc_pkg::SGC_ST_RUN;
                end
            end
            sgc_pkg::SGC_ST_RUN: begin
                if (take) begin
                    s_d.pwr = req_i.write;
                    s_d.pbank = req_i.bank;
                    s_d.prow = req_i.row;
                    s_d.pcol = req_i.col;
                    s_d.pdata = req_wdata_i;
                end
                s_d.pend = cur_v;
                // a hit issues at once, so hits stream every cycle, except a write that waits for a read beat to clear
                if (rw_ok) begin
                    s_d.pend = 1'b0;
                    // bank on bit 9, bit 8 zero, column below
                    s_d.addr = {cur_bank, 1'b0, cur_col};
                    if (cur_wr) begin
                        // write data and strobe in the same cycle
                        s_d.cmd = sgc_pkg::sgc_cmd_t'(`SGC_CMD_WR);
                        s_d.dout = cur_data;
                        s_d.oe = 1'b1;
                        // write mask acts with no delay
                        s_d.mask = '0;
                        // Write recovery before any later precharge
                        if (s_q.ras_cnt < 4'(`SGC_WR_CYC)) begin
                            s_d.ras_cnt = 4'(`SGC_WR_CYC);
                        end
                    end else begin
                        s_d.cmd = sgc_pkg::sgc_cmd_t'(`SGC_CMD_RD);
                        s_d.iss_rd = 1'b1;
                        s_d.rd_busy = s_q.cl3 ? 2'h3 : 2'h2;
                        // latency two needs the mask now
                        if (!s_q.cl3) begin
                            s_d.mask = '0;
                        end
                    end
                end else if (cur_v && !hit && s_q.wait_cnt == 4'h0) begin
                    if (s_q.open) begin
                        // precharge only once the row has aged
                        if (s_q.ras_cnt == 4'h0) begin
                            s_d.cmd = sgc_pkg::sgc_cmd_t'(`SGC_CMD_PRE);
                            s_d.addr = '0;
                            s_d.addr[`SGC_ADDR_AP] = 1'b1;
                            s_d.open = 1'b0;
                            s_d.wait_cnt = 4'(`SGC_RP_CYC - 1);
                        end
                    end else begin
                        // open the target row before access
                        // bank on bit 9, row on 8..0
                        s_d.cmd = sgc_pkg::sgc_cmd_t'(`SGC_CMD_ACT);
                        s_d.addr = {cur_bank, cur_row};
                        s_d.open = 1'b1;
                        s_d.obank = cur_bank;
                        s_d.orow = cur_row;
                        s_d.wait_cnt = 4'(`SGC_RCD_CYC - 1);
                        s_d.ras_cnt = 4'(`SGC_RAS_CYC - 1);
                    end
                end
            end
            default: begin
                s_d.st = sgc_pkg::SGC_ST_RESET;
            end
        endcase
        // A renewed host reset restarts the whole init sequence
        if (!host_up) begin
            s_d.st = sgc_pkg::SGC_ST_RESET;
            s_d.cmd = sgc_pkg::sgc_cmd_t'(`SGC_CMD_INH);
            s_d.mask = '1;
            s_d.oe = 1'b0;
            s_d.iss_rd = 1'b0;
            s_d.pend = 1'b0;
            s_d.done = 1'b0;
        end
        s_d.ready = s_d.st == sgc_pkg::SGC_ST_RUN && !s_d.pend;
    end

    // every pin but special function select, which is tied low, is launched from this rising edge register
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_q <= '0;
            s_q.cmd <= sgc_pkg::sgc_cmd_t'(`SGC_CMD_INH);
            s_q.mask <= '1;
            s_q.cke <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // return path timed from the read on the pins
    sgc_rd_pipe #(
        .DW(DW)
    ) u_rd_pipe (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .rd_issue_i(s_q.iss_rd),
        .cl3_i(s_q.cl3),
        .mem_data_i(mem_data_i),
        .rd_valid_o(rd_valid_o),
        .rd_data_o(rd_data_o)
    );

    assign req_ready_o = s_q.ready;
    assign init_done_o = s_q.done;
    assign mem_chip_select_n_o = s_q.cmd.cs_n;
    assign row_strobe_n_o = s_q.cmd.ras_n;
    assign column_strobe_n_o = s_q.cmd.cas_n;
    assign write_strobe_n_o = s_q.cmd.we_n;
    assign mem_clock_enable_o = s_q.cke;
    // special function select is never used
    assign special_function_select_o = 1'b0;
    assign mem_addr_o = s_q.addr;
    assign byte_mask_o = s_q.mask;
    assign mem_data_o = s_q.dout;
    assign mem_data_oe_o = s_q.oe;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);

    logic is_act;
    logic is_pre;
    logic is_lmr;
    logic is_rd;
    logic is_wr;
    assign is_act = s_q.cmd == sgc_pkg::sgc_cmd_t'(`SGC_CMD_ACT);
    assign is_pre = s_q.cmd == sgc_pkg::sgc_cmd_t'(`SGC_CMD_PRE);
    assign is_lmr = s_q.cmd == sgc_pkg::sgc_cmd_t'(`SGC_CMD_LMR);
    assign is_rd = s_q.cmd == sgc_pkg::sgc_cmd_t'(`SGC_CMD_RD);
    assign is_wr = s_q.cmd == sgc_pkg::sgc_cmd_t'(`SGC_CMD_WR);

    sequence seq_activate;
        is_act;
    endsequence
    sequence seq_precharge;
        is_pre && mem_addr_o[`SGC_ADDR_AP];
    endsequence

    AST_ACT_TO_RW: assert property (
        seq_activate |=> !(is_rd || is_wr) [*2])
        else $error("access too soon after activate");
    AST_PRE_TO_ACT: assert property (
        seq_precharge |=> !is_act [*3])
        else $error("activate too soon after precharge");
    AST_ACT_TO_PRE: assert property (
        seq_activate |=> !is_pre [*6])
        else $error("precharge too soon after activate");
    AST_LMR_GAP: assert property (
        is_lmr |=> s_q.cmd == sgc_pkg::sgc_cmd_t'(`SGC_CMD_NOP))
        else $error("command right after load mode");
    AST_RW_ROW_OPEN: assert property (
        (is_rd || is_wr) |-> s_q.open
            && mem_addr_o[`SGC_ADDR_BANK] == s_q.obank
            && !mem_addr_o[`SGC_ADDR_AP])
        else $error("access without its row open");
    AST_MODE_OPCODE: assert property (
        is_lmr |-> mem_addr_o[2:0] == 3'h0 && mem_addr_o[9:7] == 3'h0
            && (mem_addr_o[6:4] == 3'h2 || mem_addr_o[6:4] == 3'h3))
        else $error("bad mode opcode");
    AST_WRITE_DATA: assert property (
        is_wr |-> mem_data_oe_o && byte_mask_o == '0)
        else $error("write without data driven and unmasked");
    AST_READ_MASK: assert property (
        is_rd |-> if (s_q.cl3) (##1 (byte_mask_o == '0))
            else (byte_mask_o == '0))
        else $error("read beat masked");
    AST_FIRST_CMD: assert property (
        s_q.st == sgc_pkg::SGC_ST_RESET && host_up |=> seq_precharge)
        else $error("first command after reset is not precharge");
    AST_INIT_ORDER: assert property (
        (is_rd || is_wr || is_act) |-> s_q.done)
        else $error("access before mode register loaded");
    AST_PIN_LEVELS: assert property (
        mem_clock_enable_o && !special_function_select_o)
        else $error("clock enable or special function wrong");
endmodule

/* File: hw/sgc_pkg.sv */
// Types shared by the frame buffer memory controller files.
// Assumes nothing beyond the constants header.
package sgc_pkg;

    typedef enum logic [2:0] {
        SGC_ST_RESET,
        SGC_ST_INIT_PRE,
        SGC_ST_INIT_MRD,
        SGC_ST_RUN
    } sgc_fsm_t;

    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
    } sgc_cmd_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic bank;
        logic [8:0] row;
        logic [7:0] col;
    } sgc_req_t;

endpackage

/* File: hw/sgc_rd_pipe.sv */
// Read return path: tracks reads in flight and captures the data beat.
// Assumes rd_issue_i is high in the cycle a read command is on the pins.
`timescale 1ns/10ps
`include "sgc_consts.svh"

module sgc_rd_pipe #(
    parameter int DW = `SGC_DW_NARROW
) (
    input logic clk_sys_i,
    input logic nrst_i,
    input logic rd_issue_i,
    input logic cl3_i,
    input logic [DW-1:0] mem_data_i,
    output logic rd_valid_o,
    output logic [DW-1:0] rd_data_o
);
    typedef struct packed {
        logic [3:0] sh;
        logic [DW-1:0] cap;
        logic [DW-1:0] dat;
        logic vld;
    } sgc_pipe_regs_t;

    sgc_pipe_regs_t s_q, s_d;
    logic hit;

    if (DW != `SGC_DW_NARROW && DW != `SGC_DW_WIDE) begin : g_chk
        $error("sgc_rd_pipe: DW must be 64 or 128");
    end

    // beat lands latency edges after the memory sees the read
    assign hit = cl3_i ? s_q.sh[3] : s_q.sh[2];

    always_comb begin
        s_d = s_q;
        s_d.sh = {s_q.sh[2:0], rd_issue_i};
        // Pin data always sampled; only the flagged beat moves on
        s_d.cap = mem_data_i;
        s_d.vld = hit;
        if (hit) begin
            s_d.dat = s_q.cap;
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rd_valid_o = s_q.vld;
    assign rd_data_o = s_q.dat;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);

    sequence seq_rd2;
        rd_issue_i && !cl3_i;
    endsequence
    sequence seq_rd3;
        rd_issue_i && cl3_i;
    endsequence

    AST_RD_CAPTURE_CL2: assert property (
        seq_rd2 ##1 !cl3_i [*3] |=> rd_valid_o)
        else $error("read beat not returned at latency two");
    AST_RD_CAPTURE_CL3: assert property (
        seq_rd3 ##1 cl3_i [*4] |=> rd_valid_o)
        else $error("read beat not returned at latency three");
endmodule

/* File: hw/sgc_sync.sv */
// Two-flop synchroniser for levels arriving on pins.
// Assumes the destination clock is clk_sys_i.
`timescale 1ns/10ps

module sgc_sync #(
    parameter int W = 1
) (
    input logic clk_sys_i,
    input logic nrst_i,
    input logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } sgc_sync_regs_t;

    sgc_sync_regs_t s_q, s_d;

    if (W < 1) begin : g_chk
        $error("sgc_sync: W must be at least 1");
    end

    always_comb begin
        s_d = s_q;
        s_d.meta = async_i;
        s_d.sync = s_q.meta;
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign sync_o = s_q.sync;
endmodule

/* File: tb/sgc_mem_model.sv */
// Behavioural model of the graphics memory chips facing the controller.
// Assumes one memory clock equal to clk_sys_i; counts rule breaks.
`timescale 1ns/10ps
`include "sgc_consts.svh"

module sgc_mem_model #(
    parameter int DW = `SGC_DW_WIDE
) (
    input logic clk_sys_i,
    input logic [3:0] cmd_i,
    input logic [9:0] addr_i,
    input logic [DW/8-1:0] mask_i,
    input logic [DW-1:0] data_i,
    output logic [DW-1:0] data_o,
    output int viol_o
);
    logic [DW-1:0] mem [int];
    logic [8:0] row_q [2];
    logic [1:0] open_q;
    logic [6:0] mode_q;
    logic mode_ok;
    logic [DW-1:0] pd [4];
    logic pv [4];
    logic [DW/8-1:0] mk [2];
    int cyc, t_act, t_pre, t_lmr, key;

    initial begin
        t_act = -99;
        t_pre = -99;
        t_lmr = -99;
        cyc = 0;
        open_q = 2'h0;
        mode_ok = 1'b0;
        viol_o = 0;
        data_o = '0;
    end

    always @(posedge clk_sys_i) begin
        cyc++;
        for (int i = 3; i > 0; i--) begin
            pd[i] = pd[i-1];
            pv[i] = pv[i-1];
        end
        pv[0] = 1'b0;
        mk[1] = mk[0];
        mk[0] = mask_i;
        if (!cmd_i[3] && cmd_i != `SGC_CMD_NOP && cyc - t_lmr < 2)
            viol_o++;
        case (cmd_i)
            `SGC_CMD_ACT: begin
                if (cyc - t_pre < 4 || open_q[addr_i[9]])
                    viol_o++;
                open_q[addr_i[9]] = 1'b1;
                row_q[addr_i[9]] = addr_i[8:0];
                t_act = cyc;
            end
            `SGC_CMD_RD, `SGC_CMD_WR: begin
                if (!open_q[addr_i[9]] || !mode_ok || addr_i[8]
                    || cyc - t_act < 3)
                    viol_o++;
                key = {addr_i[9], row_q[addr_i[9]], addr_i[7:0]};
                if (cmd_i == `SGC_CMD_RD) begin
                    pv[0] = 1'b1;
                    pd[0] = mem.exists(key) ? mem[key] : '0;
                end else if (mask_i == '0) begin
                    mem[key] = data_i;
                end
            end
            `SGC_CMD_PRE: begin
                if ((|open_q && cyc - t_act < 7) || !addr_i[8])
                    viol_o++;
                open_q = 2'h0;
                t_pre = cyc;
            end
            `SGC_CMD_LMR: begin
                if (|open_q)
                    viol_o++;
                mode_q = addr_i[6:0];
                mode_ok = 1'b1;
                t_lmr = cyc;
            end
            default: ;
        endcase
        if (pv[mode_q[6:4] - 3'h1] && mk[1] == '0)
            data_o <= pd[mode_q[6:4] - 3'h1];
        else
            data_o <= ~data_o;
    end
endmodule

/* File: tb/tb.sv */
// Self-checking bench for the frame buffer memory controller.
// Assumes the design files and the memory model are compiled first.
`timescale 1ns/10ps
`include "sgc_consts.svh"

module tb;
    localparam int DW = `SGC_DW_WIDE;
    logic clk_sys_i = 0, nrst_i = 0, host_reset_n_i = 0, lat3 = 0;
    sgc_pkg::sgc_req_t req = '0;
    logic [DW-1:0] wdata = '0, rdata, mdo, mdi;
    logic ready, done, rvalid, cs_n, ras_n, cas_n, we_n, cke, special_function_select, oe;
    logic [9:0] addr;
    logic [DW/8-1:0] mask;
    logic [31:0] r;
    int mismatches = 0, comparisons = 0, seed = 69, viol, cyc = 0, n;
    logic [DW-1:0] exp_mem [int];
    logic [DW-1:0] exp_q [$];
    int t_q [$];

    always #12.5 clk_sys_i = ~clk_sys_i;

    sgc_ctrl #(.DW(DW)) dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
        .host_reset_n_i(host_reset_n_i), .cfg_read_lat3_i(lat3),
        .req_i(req), .req_wdata_i(wdata), .req_ready_o(ready),
        .init_done_o(done), .rd_valid_o(rvalid), .rd_data_o(rdata),
        .mem_chip_select_n_o(cs_n), .row_strobe_n_o(ras_n),
        .column_strobe_n_o(cas_n), .write_strobe_n_o(we_n),
        .mem_clock_enable_o(cke), .special_function_select_o(special_function_select),
        .mem_addr_o(addr), .byte_mask_o(mask), .mem_data_o(mdo),
        .mem_data_oe_o(oe), .mem_data_i(mdi));

    sgc_mem_model #(.DW(DW)) mem (.clk_sys_i(clk_sys_i),
        .cmd_i({cs_n, ras_n, cas_n, we_n}), .addr_i(addr), .mask_i(mask),
        .data_i(oe ? mdo : ~mdo), .data_o(mdi), .viol_o(viol));

    task automatic check(input string what, input logic [DW-1:0] e, s);
        comparisons++;
        if (e !== s) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, e, s);
        end
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Sixteen places: two banks, two rows, four columns using bit 7
    function automatic logic [17:0] place(input logic [3:0] k);
        return {k[3], k[2], 7'h00, k[2], k[0], 5'h00, k[1:0]};
    endfunction

    task automatic send(input logic wr, input logic [17:0] a,
                        input logic [DW-1:0] d);
        req = {1'b1, wr, a};
        wdata = d;
        n = 0;
        while (ready !== 1'b1 && n < 100) begin
            @(negedge clk_sys_i);
            n++;
        end
        if (n == 100)
            mismatches++;
        @(negedge clk_sys_i);
        if (wr)
            exp_mem[a] = d;
        else
            exp_q.push_back(exp_mem[a]);
    endtask

    // Settled outputs are looked at on the falling edge
    always @(negedge clk_sys_i) begin
        cyc++;
        if (nrst_i) begin
            check("enable pins", 2'b10, {cke, special_function_select});
            if ({cs_n, ras_n, cas_n, we_n} === `SGC_CMD_RD)
                t_q.push_back(cyc);
            if (rvalid === 1'b1) begin
                check("read latency", lat3 + 4, cyc - t_q.pop_front());
                check("read data", exp_q.pop_front(), rdata);
            end
        end
    end

    initial begin
        repeat (2) @(negedge clk_sys_i);
        nrst_i = 1;
        for (int cl = 0; cl < 2; cl++) begin
            host_reset_n_i = 0;
            lat3 = cl[0];
            repeat (3) @(negedge clk_sys_i);
            check("init restart", '0, done);
            host_reset_n_i = 1;
            n = 0;
            while (done !== 1'b1 && n < 50) begin
                @(negedge clk_sys_i);
                n++;
            end
            check("init time", 1, n < 50);
            check("mode", {lat3 ? 3'h3 : 3'h2, 4'h0}, mem.mode_q);
            // Fill every place first, back to back where rows hit
            for (int i = 0; i < 16; i++)
                send(1'b1, place(i[3:0]), {$random(seed), $random(seed),
                     $random(seed), $random(seed)});
            // Mixed traffic gives hits, bank changes and read to write
            for (int i = 0; i < 48; i++) begin
                r = $random(seed);
                send(r[4], place(r[3:0]), {$random(seed), $random(seed),
                     $random(seed), $random(seed)});
            end
            req = '0;
            // A last miss may wait out row age, precharge and activate
            repeat (30) @(negedge clk_sys_i);
            check("reads left", 0, exp_q.size());
        end
        check("memory timing", 0, viol);
        results();
    end

    // Traffic should end well inside this span
    initial begin
        #(25 * 8000);
        mismatches++;
        results();
    end
endmodule
